// ### shared/acp_pkg.sv
// Constants and types shared by the converter configuration block
// What this block does
// - Reset pin held high selects pin mode; straps set operating modes
// - Pin mode needs no reset; strap levels alone configure the device
// - Reset pin low turns select, clock and data pins into a serial port
// - Reset pin pulse over 10 ns returns every register to default
// - Writing one to soft-reset bit restores defaults; bit self-clears
// - Shift only while select low; data sampled on falling serial clock
// - Every 16th falling edge commits a word; words may run back to back
// - Bits after the last whole 16-bit word are dropped
// - Word is eight address bits first, then eight data bits
// - Serial clock from 20 MHz down to hertz, any duty cycle
// - Reference register bit decides only while reference strap is low
// - Code format register bit decides only while format strap is low
// - Nonzero interface field overrides format strap's interface choice; 00 lets strap decide
// - Format strap four levels pick code format and output interface
// - Reference strap: ends internal, middle levels external
// - Clock strap low default speed, high low-speed mode
// - Data strap low normal, high global standby
// - CMOS: select strap shifts strobe late 3, late 5, early 3, default
// - LVDS: select strap late 7/6, late 7/6, late 3, default
package acp_pkg;

    // Register offsets
    localparam logic [7:0] ACP_OFS_FORMAT = 8'h63;
    localparam logic [7:0] ACP_OFS_IFACE = 8'h6C;
    localparam logic [7:0] ACP_OFS_REF = 8'h6D;

    // Field positions
    localparam int ACP_BIT_STANDBY = 7;
    localparam int ACP_BIT_CODE_FMT = 3;
    localparam int ACP_BIT_LOW_SPEED = 0;
    localparam int ACP_BIT_SOFT_RST = 1;
    localparam int ACP_BIT_IFACE_LO = 3;
    localparam int ACP_BIT_REF = 4;

    // Reset values
    localparam logic [7:0] ACP_RST_FORMAT = 8'h00;
    localparam logic [7:0] ACP_RST_IFACE = 8'h00;
    localparam logic [7:0] ACP_RST_REF = 8'h00;

    // Interface field codes
    localparam logic [1:0] ACP_IFACE_STRAP = 2'h0;
    localparam logic [1:0] ACP_IFACE_LVDS = 2'h1;

    // Serial word layout
    localparam int ACP_WORD_BITS = 16;
    localparam int ACP_ADDR_BITS = 8;

    // Timing: least reset pulse width
    localparam int ACP_CLK_PERIOD_PS = 8000;
    localparam int ACP_RST_PULSE_MIN_PS = 10000;
    localparam int ACP_RST_PULSE_CYC =
        (ACP_RST_PULSE_MIN_PS + ACP_CLK_PERIOD_PS - 1) / ACP_CLK_PERIOD_PS;

    // Strap level as digitised by the pin comparators
    typedef enum logic [1:0] {
        ACP_LVL_GND = 2'h0,
        ACP_LVL_3_8 = 2'h1,
        ACP_LVL_5_8 = 2'h2,
        ACP_LVL_FULL = 2'h3
    } acp_level_t;

    // Output strobe placement, in 36ths of a sample period
    typedef enum logic [2:0] {
        ACP_SHIFT_DEFAULT = 3'h0,
        ACP_SHIFT_CMOS_LATE3 = 3'h1,
        ACP_SHIFT_CMOS_LATE5 = 3'h2,
        ACP_SHIFT_CMOS_EARLY3 = 3'h3,
        ACP_SHIFT_LVDS_LATE7_6 = 3'h4,
        ACP_SHIFT_LVDS_LATE3 = 3'h5
    } acp_shift_t;

    // Effective configuration driven to the converter
    typedef struct packed {
        logic offset_binary;
        logic iface_cmos;
        logic ext_ref;
        logic low_speed;
        logic standby;
        acp_shift_t strobe_shift;
    } acp_cfg_t;

    // Committed serial word
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } acp_word_t;

    localparam acp_cfg_t ACP_CFG_RESET = '{
        offset_binary: 1'b0, iface_cmos: 1'b0, ext_ref: 1'b0,
        low_speed: 1'b0, standby: 1'b0, strobe_shift: ACP_SHIFT_DEFAULT};

endpackage : acp_pkg

// ### hdl/acp_config.sv
// Serial and strap configuration front end of the converter
`timescale 1ns/1ps
module acp_config
    import acp_pkg::*;
(
    // System clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Device reset pin
    input wire logic hw_reset_pin_i,
    // Serial port pins; clock and data are also straps in pin mode
    input wire logic serial_clk_i,
    input wire logic serial_select_n_i,
    input wire logic serial_in_line_i,
    // Digitised multi-level strap levels
    input wire logic [1:0] format_strap_pin_i,
    input wire logic [1:0] ref_strap_pin_i,
    input wire logic [1:0] select_strap_level_i,
    // Effective configuration
    output acp_cfg_t cfg_o,
    output logic pin_mode_o
);

    // Strap decoders, used in pin mode and in the serial priority paths
    function automatic logic fmt_offset(input logic [1:0] lvl);
        fmt_offset = (lvl == ACP_LVL_5_8) || (lvl == ACP_LVL_FULL);
    endfunction : fmt_offset

    function automatic logic fmt_cmos(input logic [1:0] lvl);
        fmt_cmos = (lvl == ACP_LVL_3_8) || (lvl == ACP_LVL_5_8);
    endfunction : fmt_cmos

    function automatic logic ref_external(input logic [1:0] lvl);
        ref_external = (lvl == ACP_LVL_3_8) || (lvl == ACP_LVL_5_8);
    endfunction : ref_external

    // ---------------- Serial clock domain ----------------

    // Counter clears while select is high or the part is in pin mode
    logic ser_clr;
    assign ser_clr = reset_i | serial_select_n_i | hw_reset_pin_i;

    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic [14:0] shift_q;
    logic [14:0] shift_d;
    acp_word_t word_q;
    acp_word_t word_d;
    logic word_tog_q;
    logic word_tog_d;

    always_comb begin
        bit_cnt_d = bit_cnt_q + 4'h1;
        shift_d = {shift_q[13:0], serial_in_line_i};
        word_d = word_q;
        word_tog_d = word_tog_q;
        if (bit_cnt_q == 4'hF) begin
            // Address shifted in first lands in the upper byte
            word_d = {shift_q, serial_in_line_i};
            word_tog_d = ~word_tog_q;
        end
    end

    // Counter is cleared by select high, so a partial word never commits
    always_ff @(negedge serial_clk_i or posedge ser_clr) begin
        if (ser_clr) begin
            bit_cnt_q <= 4'h0;
            shift_q <= 15'h0000;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
        end
    end

    // Word and toggle survive select going high so the crossing completes
    always_ff @(negedge serial_clk_i or posedge reset_i) begin
        if (reset_i) begin
            word_q <= '0;
            word_tog_q <= 1'b0;
        end else begin
            word_q <= word_d;
            word_tog_q <= word_tog_d;
        end
    end

    // ---------------- System clock domain ----------------

    // Pin inputs: three stages, a change counts when stages two and three
    // agree. Index map: 0 reset pin, 1 clock strap, 2 data strap,
    // 3-4 format, 5-6 reference, 7-8 select level, 9 word toggle.
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] stable_q;
    logic [NSYNC-1:0] stable_d;

    // A reset pulse barely over the minimum width can meet just one of the
    // sampling edges; hold it until the next edge sees the pin low
    logic rst_catch_q;

    always_ff @(posedge clk_i or posedge reset_i
                or posedge hw_reset_pin_i) begin
        if (hw_reset_pin_i) begin
            rst_catch_q <= 1'b1;
        end else begin
            rst_catch_q <= 1'b0;
        end
    end

    assign pin_raw = {word_tog_q, select_strap_level_i, ref_strap_pin_i,
                      format_strap_pin_i, serial_in_line_i, serial_clk_i,
                      rst_catch_q};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            assign stable_d[gi] = (s2_q == s3_q) ? s3_q : stable_q[gi];
        end
    endgenerate

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stable_q <= '0;
        end else begin
            stable_q <= stable_d;
        end
    end

    logic rst_pin;
    logic clk_strap;
    logic data_strap;
    logic [1:0] fmt_lvl;
    logic [1:0] ref_lvl;
    logic [1:0] sel_lvl;
    logic tog_seen;

    assign rst_pin = stable_q[0];
    assign clk_strap = stable_q[1];
    assign data_strap = stable_q[2];
    assign fmt_lvl = stable_q[4:3];
    assign ref_lvl = stable_q[6:5];
    assign sel_lvl = stable_q[8:7];
    assign tog_seen = stable_q[9];

    // Configuration registers and word acknowledge
    logic [7:0] reg_format_q;
    logic [7:0] reg_format_d;
    logic [7:0] reg_iface_q;
    logic [7:0] reg_iface_d;
    logic [7:0] reg_ref_q;
    logic [7:0] reg_ref_d;
    logic tog_ack_q;
    logic tog_ack_d;
    logic word_new;

    // The word is held for sixteen serial clocks, far longer than the
    // crossing, so it is read directly once the toggle is seen
    assign word_new = tog_seen != tog_ack_q;

    always_comb begin
        reg_format_d = reg_format_q;
        reg_iface_d = reg_iface_q;
        reg_ref_d = reg_ref_q;
        tog_ack_d = tog_seen;
        if (rst_pin) begin
            // Held high or pulsed: defaults, no serial writes taken
            reg_format_d = ACP_RST_FORMAT;
            reg_iface_d = ACP_RST_IFACE;
            reg_ref_d = ACP_RST_REF;
        end else if (word_new) begin
            case (word_q.addr)
                ACP_OFS_FORMAT: begin
                    reg_format_d = word_q.data;
                end
                ACP_OFS_IFACE: begin
                    if (word_q.data[ACP_BIT_SOFT_RST]) begin
                        // Soft reset is never stored, so it reads back clear
                        reg_format_d = ACP_RST_FORMAT;
                        reg_iface_d = ACP_RST_IFACE;
                        reg_ref_d = ACP_RST_REF;
                    end else begin
                        reg_iface_d = word_q.data;
                    end
                end
                ACP_OFS_REF: begin
                    reg_ref_d = word_q.data;
                end
                default: begin
                    reg_format_d = reg_format_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_format_q <= ACP_RST_FORMAT;
            reg_iface_q <= ACP_RST_IFACE;
            reg_ref_q <= ACP_RST_REF;
            tog_ack_q <= 1'b0;
        end else begin
            reg_format_q <= reg_format_d;
            reg_iface_q <= reg_iface_d;
            reg_ref_q <= reg_ref_d;
            tog_ack_q <= tog_ack_d;
        end
    end

    // Effective configuration
    acp_cfg_t cfg_q;
    acp_cfg_t cfg_d;
    logic pin_mode_q;
    logic pin_mode_d;
    logic [1:0] odi;

    assign odi = reg_iface_q[ACP_BIT_IFACE_LO+1:ACP_BIT_IFACE_LO];

    always_comb begin
        cfg_d = ACP_CFG_RESET;
        pin_mode_d = rst_pin;
        if (rst_pin) begin
            // Straps alone decide; no reset needed in this mode
            cfg_d.offset_binary = fmt_offset(fmt_lvl);
            cfg_d.iface_cmos = fmt_cmos(fmt_lvl);
            cfg_d.ext_ref = ref_external(ref_lvl);
            cfg_d.low_speed = clk_strap;
            cfg_d.standby = data_strap;
            if (fmt_cmos(fmt_lvl)) begin
                case (sel_lvl)
                    ACP_LVL_GND: cfg_d.strobe_shift = ACP_SHIFT_CMOS_LATE3;
                    ACP_LVL_3_8: cfg_d.strobe_shift = ACP_SHIFT_CMOS_LATE5;
                    ACP_LVL_5_8: cfg_d.strobe_shift = ACP_SHIFT_CMOS_EARLY3;
                    default: cfg_d.strobe_shift = ACP_SHIFT_DEFAULT;
                endcase
            end else begin
                case (sel_lvl)
                    ACP_LVL_GND: cfg_d.strobe_shift = ACP_SHIFT_LVDS_LATE7_6;
                    ACP_LVL_3_8: cfg_d.strobe_shift = ACP_SHIFT_LVDS_LATE7_6;
                    ACP_LVL_5_8: cfg_d.strobe_shift = ACP_SHIFT_LVDS_LATE3;
                    default: cfg_d.strobe_shift = ACP_SHIFT_DEFAULT;
                endcase
            end
        end else begin
            // Serial mode: a grounded strap hands control to the register,
            // which is also what a serial-only board provides
            if (fmt_lvl == ACP_LVL_GND) begin
                cfg_d.offset_binary = reg_format_q[ACP_BIT_CODE_FMT];
            end else begin
                cfg_d.offset_binary = fmt_offset(fmt_lvl);
            end
            if (odi == ACP_IFACE_STRAP) begin
                cfg_d.iface_cmos = fmt_cmos(fmt_lvl);
            end else begin
                cfg_d.iface_cmos = (odi != ACP_IFACE_LVDS);
            end
            if (ref_lvl == ACP_LVL_GND) begin
                cfg_d.ext_ref = reg_ref_q[ACP_BIT_REF];
            end else begin
                cfg_d.ext_ref = ref_external(ref_lvl);
            end
            cfg_d.low_speed = reg_format_q[ACP_BIT_LOW_SPEED];
            cfg_d.standby = reg_format_q[ACP_BIT_STANDBY];
            cfg_d.strobe_shift = ACP_SHIFT_DEFAULT;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_q <= ACP_CFG_RESET;
            pin_mode_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            pin_mode_q <= pin_mode_d;
        end
    end

    assign cfg_o = cfg_q;
    assign pin_mode_o = pin_mode_q;

endmodule : acp_config

// ### tb/acp_checker.sv
// Port-level assertions for the configuration front end
`timescale 1ns/1ps
module acp_checker
    import acp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Pins
    input wire logic hw_reset_pin_i,
    input wire logic serial_clk_i,
    input wire logic serial_select_n_i,
    input wire logic serial_in_line_i,
    input wire logic [1:0] format_strap_pin_i,
    input wire logic [1:0] ref_strap_pin_i,
    input wire logic [1:0] select_strap_level_i,
    // Outputs
    input wire acp_cfg_t cfg_o,
    input wire logic pin_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Eight stable samples cover the five-edge strap path with margin
    property p_on; hw_reset_pin_i [*8] |-> pin_mode_o; endproperty
    a_on: assert property (p_on) else $error("pin mode missed");
    property p_off; !hw_reset_pin_i [*8] |-> !pin_mode_o; endproperty
    a_off: assert property (p_off) else $error("pin mode stuck");
    property p_slow;
        (pin_mode_o && serial_clk_i) [*8] |-> cfg_o.low_speed;
    endproperty
    a_slow: assert property (p_slow) else $error("low speed");
    property p_stby;
        (pin_mode_o && serial_in_line_i) [*8] |-> cfg_o.standby;
    endproperty
    a_stby: assert property (p_stby) else $error("standby");
    property p_fmt; (pin_mode_o && format_strap_pin_i == 2'h2) [*8]
        |-> cfg_o.offset_binary && cfg_o.iface_cmos; endproperty
    a_fmt: assert property (p_fmt) else $error("format strap");
    property p_ref; (pin_mode_o && ref_strap_pin_i == 2'h1) [*8]
        |-> cfg_o.ext_ref; endproperty
    a_ref: assert property (p_ref) else $error("reference strap");
    property p_cmos; (pin_mode_o && format_strap_pin_i == 2'h1 &&
        select_strap_level_i == 2'h2) [*8]
        |-> cfg_o.strobe_shift == ACP_SHIFT_CMOS_EARLY3; endproperty
    a_cmos: assert property (p_cmos) else $error("cmos shift");
    property p_lvds; (pin_mode_o && format_strap_pin_i == 2'h3 &&
        select_strap_level_i == 2'h0) [*8]
        |-> cfg_o.strobe_shift == ACP_SHIFT_LVDS_LATE7_6; endproperty
    a_lvds: assert property (p_lvds) else $error("lvds shift");
    property p_hold; (serial_select_n_i && !hw_reset_pin_i &&
        $stable(format_strap_pin_i) && $stable(ref_strap_pin_i)) [*8]
        |=> $stable(cfg_o); endproperty
    a_hold: assert property (p_hold) else $error("idle change");
endmodule : acp_checker

bind acp_config acp_checker i_acp_checker (.clk_i(clk_i),
    .reset_i(reset_i), .hw_reset_pin_i(hw_reset_pin_i),
    .serial_clk_i(serial_clk_i), .serial_select_n_i(serial_select_n_i),
    .serial_in_line_i(serial_in_line_i),
    .format_strap_pin_i(format_strap_pin_i),
    .ref_strap_pin_i(ref_strap_pin_i),
    .select_strap_level_i(select_strap_level_i),
    .cfg_o(cfg_o), .pin_mode_o(pin_mode_o));

// ### tb/acp_host.sv
// Host model driving the serial configuration pins
`timescale 1ns/1ps
module acp_host (
    // Serial pins toward the device
    output logic sclk_o,
    output logic sen_n_o,
    output logic sdo_o
);
    initial begin
        sclk_o = 1'h1;
        sen_n_o = 1'h1;
        sdo_o = 1'h0;
    end
    task automatic straps(input logic c, input logic d);
        sclk_o <= c;
        sdo_o <= d;
    endtask : straps
    // Released data line shows the inverse of its last bit
    task automatic sel(input logic n);
        sclk_o = 1'h1;
        #37;
        sen_n_o = n;
        if (n) sdo_o = ~sdo_o;
        #37;
    endtask : sel
    // Short low phase keeps the clock off even duty
    task automatic put(input logic b);
        sdo_o = b;
        #55 sclk_o = 1'h0;
        #50 sclk_o = 1'h1;
        #55;
    endtask : put
    task automatic word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) put(w[i]);
    endtask : word
endmodule : acp_host

// ### tb/testbench.sv
// Self-checking bench for the configuration front end
`timescale 1ns/1ps
module testbench;
    import acp_pkg::*;
    logic clk_i = 1'h0;
    logic reset_i;
    logic hw;
    logic [1:0] fs;
    logic [1:0] rs;
    logic [1:0] ss;
    logic sclk;
    logic sen_n;
    logic sdo;
    logic pm;
    acp_cfg_t cfg;
    logic [7:0] g63 = 8'h00;
    logic [7:0] g6c = 8'h00;
    logic [7:0] g6d = 8'h00;
    int n_mismatch = 0;
    int n_checks = 0;
    always #4 clk_i = ~clk_i;
    acp_host i_acp_host (.sclk_o(sclk), .sen_n_o(sen_n), .sdo_o(sdo));
    acp_config i_acp_config (.clk_i(clk_i), .reset_i(reset_i),
        .hw_reset_pin_i(hw), .serial_clk_i(sclk),
        .serial_select_n_i(sen_n), .serial_in_line_i(sdo),
        .format_strap_pin_i(fs), .ref_strap_pin_i(rs),
        .select_strap_level_i(ss), .cfg_o(cfg), .pin_mode_o(pm));
    function automatic acp_cfg_t exp_cfg(input logic pin);
        acp_cfg_t e;
        logic cm;
        e = ACP_CFG_RESET;
        cm = (fs == 2'h1) || (fs == 2'h2);
        if (!pin && g6c[4:3] != 2'h0) cm = g6c[4:3] != ACP_IFACE_LVDS;
        e.iface_cmos = cm;
        e.offset_binary = (pin || fs != 2'h0) ? fs[1] : g63[3];
        e.ext_ref = (pin || rs != 2'h0) ? rs[1] ^ rs[0] : g6d[4];
        e.low_speed = pin ? sclk : g63[0];
        e.standby = pin ? sdo : g63[7];
        if (pin) begin
            case ({cm, ss})
                3'h0, 3'h1: e.strobe_shift = ACP_SHIFT_LVDS_LATE7_6;
                3'h2: e.strobe_shift = ACP_SHIFT_LVDS_LATE3;
                3'h4: e.strobe_shift = ACP_SHIFT_CMOS_LATE3;
                3'h5: e.strobe_shift = ACP_SHIFT_CMOS_LATE5;
                3'h6: e.strobe_shift = ACP_SHIFT_CMOS_EARLY3;
                default: e.strobe_shift = ACP_SHIFT_DEFAULT;
            endcase
        end
        return e;
    endfunction : exp_cfg
    task automatic chk(input logic pin);
        acp_cfg_t e;
        repeat (12) @(posedge clk_i);
        #1;
        e = exp_cfg(pin);
        n_checks++;
        if (cfg !== e || pm !== pin) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: cfg %h not %h", $time, cfg, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_acp_host.sel(1'h0);
        i_acp_host.word({a, d});
        i_acp_host.sel(1'h1);
        if (a == ACP_OFS_FORMAT) g63 = d;
        if (a == ACP_OFS_REF) g6d = d;
        if (a == ACP_OFS_IFACE) g6c = d;
        if (a == ACP_OFS_IFACE && d[ACP_BIT_SOFT_RST]) {g63, g6c, g6d} = '0;
        chk(1'h0);
    endtask : wr
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        reset_i = 1'h1;
        hw = 1'h0;
        fs = 2'h0;
        rs = 2'h0;
        ss = 2'h0;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'h0;
        hw <= 1'h1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            fs <= i[3:2];
            rs <= i[3:2];
            ss <= i[1:0];
            i_acp_host.straps(i[0], i[2]);
            chk(1'h1);
        end
        $display("strap test done");
        @(posedge clk_i);
        hw <= 1'h0;
        fs <= 2'h0;
        rs <= 2'h0;
        i_acp_host.straps(1'h1, 1'h0);
        chk(1'h0);
        wr(ACP_OFS_FORMAT, 8'h89);
        wr(ACP_OFS_REF, 8'h10);
        wr(8'h5D, 8'hFF);
        @(posedge clk_i);
        fs <= 2'h1;
        rs <= 2'h3;
        for (int k = 0; k < 4; k++) wr(ACP_OFS_IFACE, 8'(k * 8));
        $display("priority test done");
        @(posedge clk_i);
        fs <= 2'h0;
        rs <= 2'h0;
        i_acp_host.sel(1'h0);
        i_acp_host.word({ACP_OFS_FORMAT, 8'h00});
        i_acp_host.word({ACP_OFS_REF, 8'h00});
        for (int b = 0; b < 5; b++) i_acp_host.put(1'h1);
        i_acp_host.sel(1'h1);
        {g63, g6d} = 16'h0000;
        chk(1'h0);
        i_acp_host.sel(1'h0);
        for (int b = 7; b >= 0; b--) i_acp_host.put(ACP_OFS_FORMAT[b]);
        i_acp_host.sel(1'h1);
        wr(ACP_OFS_REF, 8'h10);
        $display("framing test done");
        wr(ACP_OFS_IFACE, 8'h1A);
        wr(ACP_OFS_FORMAT, 8'h89);
        @(posedge clk_i);
        hw <= 1'h1;
        // Shortest whole-cycle pulse above the least width
        repeat (ACP_RST_PULSE_CYC) @(posedge clk_i);
        hw <= 1'h0;
        {g63, g6c, g6d} = 24'h000000;
        chk(1'h0);
        $display("reset test done");
        tally_and_finish;
    end
endmodule : testbench
